// ---- shared/crol_pkg.sv ----
// Functional notes
// - Four keys, burn command, 10 ms, fire
// - Fuse array programs once, later burns ignored
// - Registers stay writable after fuse programming
// - Reload from fuses or EEPROM on reset
// - Blank fuses: registers zero, fault 0x18
// - Fault flags cleared by writing zero, set only by fault events
// - Serial writes overwrite registers 0x00 to 0x0B after load
// - Serial port programs registers; fuse or EEPROM image
// - Register 0x00 main field layout
// - Autogain code decodes 3 Hz to 98 kHz
// - Enable polarity bit selects enabling level
// - Direction polarity bit inverts direction input
// - Register 0x04 drive field layout
// - Register 0x0A protection and loop gain layout
// - 24-bit frame, shifted while select high
// - Strap high: master read from serial EEPROM
package crol_pkg;

   // ==========================================================
   // Sizes
   localparam int unsigned NREG       = 12;
   localparam int unsigned DW         = 16;
   localparam int unsigned FRAME_BITS = 24;
   localparam int unsigned HDR_BITS   = 8;
   localparam int unsigned NFAULT     = 6;

   // ==========================================================
   // Register addresses
   localparam logic [6:0] ADDR_MAIN  = 7'h00;
   localparam logic [6:0] ADDR_LAST  = 7'h0b;
   localparam logic [6:0] ADDR_DRIVE = 7'h04;
   localparam logic [6:0] ADDR_PROT  = 7'h0a;
   localparam logic [6:0] ADDR_FAULT = 7'h2a;
   localparam logic [6:0] ADDR_KEY   = 7'h2d;
   localparam logic [6:0] ADDR_BURN  = 7'h39;

   // ==========================================================
   // Reset values and masks
   localparam logic [15:0] CFG_RST    = 16'h0000;
   localparam logic [15:0] FAULT_RST  = 16'h0018;
   localparam logic [15:0] FAULT_MASK = 16'h003f;

   // ==========================================================
   // Fuse unlock sequence
   localparam logic [3:0][15:0] KEYS = {16'h1819, 16'h1617, 16'h1415, 16'h1213};
   localparam logic [15:0] BURN_CMD  = 16'h0002;
   localparam logic [15:0] BURN_FIRE = 16'h0edd;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned BURN_WAIT_MS  = 10;
   localparam int unsigned BURN_WAIT_CYC =
      (BURN_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EE_HALF_NS    = 1000;
   localparam int unsigned EE_HALF_CYC   =
      (EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0]  SETTLE_CYC    = 3'h4;

   // ==========================================================
   // Serial EEPROM read command
   localparam logic [2:0] EE_READ_OP   = 3'h6;
   localparam logic [4:0] EE_CMD_BITS  = 5'h09;
   localparam logic [4:0] EE_DATA_BITS = 5'h10;

   // ==========================================================
   // Autogain setpoint table in Hz
   localparam logic [15:0][16:0] AG_HZ = {
      17'h17ed0, 17'h0bf68, 17'h05dc0, 17'h02ee0,
      17'h01770, 17'h00bb8, 17'h005dc, 17'h002fb,
      17'h0017e, 17'h000bf, 17'h0005f, 17'h00030,
      17'h00018, 17'h0000c, 17'h00006, 17'h00003};

   // ==========================================================
   // Types
   typedef logic [NREG-1:0][DW-1:0] crol_image_t;

   typedef struct packed {
      logic       rw;
      logic [6:0] addr;
      logic [15:0] data;
   } crol_frame_t;

   typedef struct packed {
      logic [3:0] autogain_setpoint_select;
      logic       enable_polarity;
      logic       direction_polarity;
      logic       brake_polarity;
      logic       sync_rectify_en;
      logic [1:0] output_pwm_freq;
      logic [1:0] speed_ctrl_select;
      logic [1:0] feedback_source_select;
      logic       brake_behaviour;
      logic       retry_en;
   } crol_main_t;

   typedef struct packed {
      logic [1:0] rsvd;
      logic [1:0] hall_reset;
      logic       hall_delay;
      logic       auto_advance_en;
      logic       auto_gain_en;
      logic       sine_commutation_en;
      logic [1:0] gate_drive_time;
      logic [2:0] dead_time;
      logic [2:0] drive_current;
   } crol_drive_t;

   typedef struct packed {
      logic [1:0] overcurrent_deglitch;
      logic [1:0] overcurrent_threshold;
      logic [1:0] overvoltage_threshold;
      logic       hall_regulator_en;
      logic       rsvd;
      logic [7:0] loop_gain;
   } crol_prot_t;

endpackage

// ---- src/crol_loader.sv ----
`timescale 1ns/1ps
// ==========================================================
// Configuration register bank with fuse and EEPROM loading
module crol_loader #(
   parameter int unsigned BURN_WAIT_CYC = crol_pkg::BURN_WAIT_CYC,
   parameter int unsigned EE_HALF_CYC   = crol_pkg::EE_HALF_CYC
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // Fuse array blank state
   input  wire logic                  otp_blank_n,
   // Strap and motor pins
   input  wire logic                  config_source_select,
   input  wire logic                  enable_pin,
   input  wire logic                  direction_input,
   // Serial clock pin
   input  wire logic                  serial_clk_in,
   output logic                       serial_clk_out,
   output logic                       serial_clk_oe,
   // Serial select pin
   input  wire logic                  serial_select_in,
   output logic                       serial_select_out,
   output logic                       serial_select_oe,
   // Serial data pins
   input  wire logic                  serial_din,
   output logic                       serial_dout,
   // Fault events from protection logic
   input  wire logic [5:0]            fault_events,
   // Configuration outputs
   output crol_pkg::crol_image_t      cfg_image,
   output crol_pkg::crol_main_t       main_cfg,
   output crol_pkg::crol_drive_t      drive_cfg,
   output crol_pkg::crol_prot_t       prot_cfg,
   output logic [15:0]                fault_flags,
   output logic [16:0]                autogain_setpoint_hz,
   output logic                       motor_enable,
   output logic                       direction_out,
   // Status
   output logic                       load_done,
   output logic                       otp_programmed,
   output logic                       burn_armed
);
   // ==========================================================
   // Declarations
   localparam int unsigned WW = $clog2(BURN_WAIT_CYC + 1);
   localparam int unsigned HW = $clog2(EE_HALF_CYC + 1);

   typedef enum logic [2:0] {
      LD_SETTLE, LD_OTP, LD_EE_GAP, LD_EE_CMD, LD_EE_DATA, LD_DONE
   } crol_ld_state_t;

   typedef enum logic [1:0] {
      BN_KEY, BN_CMD, BN_WAIT, BN_FIRE
   } crol_bn_state_t;

   logic [5:0]            sync_q;
   logic                  sclk_s;
   logic                  ssel_s;
   logic                  sdi_s;
   logic                  en_s;
   logic                  dir_s;
   logic                  strap_s;
   logic                  sclk_d_reg;
   logic                  ssel_d_reg;
   logic                  sclk_rise;
   logic                  ssel_rise;
   logic                  ssel_fall;
   crol_pkg::crol_image_t regs_reg;
   crol_pkg::crol_image_t otp_reg;
   logic                  otp_prog_reg;
   logic [15:0]           fault_reg;
   logic [15:0]           fault_next;
   crol_ld_state_t        ld_reg;
   logic [2:0]            settle_reg;
   logic [HW-1:0]         half_reg;
   logic                  tick;
   logic                  sk_reg;
   logic                  cs_reg;
   logic [8:0]            cmd_reg;
   logic [4:0]            ee_bit_reg;
   logic [3:0]            ee_word_reg;
   logic [15:0]           ee_sr_reg;
   logic                  ee_active;
   logic                  ee_wr;
   logic [15:0]           ee_wdata;
   logic [23:0]           spi_sr_reg;
   logic [4:0]            spi_cnt_reg;
   logic [15:0]           rd_sr_reg;
   logic [6:0]            rd_addr;
   logic [15:0]           rd_data;
   crol_pkg::crol_frame_t frm;
   logic                  wr_pulse;
   logic                  key_wr;
   logic                  cmd_wr;
   crol_bn_state_t        bn_reg;
   logic [1:0]            key_reg;
   logic [WW-1:0]         wait_reg;
   logic                  en_active;
   logic                  burn_go;
   logic                  motor_en_reg;
   logic                  dir_reg;
   logic [16:0]           ag_hz_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // ==========================================================
   // Pin synchronisers and edge detection
   crol_sync #(
      .W (6)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({serial_clk_in, serial_select_in, serial_din,
                enable_pin, direction_input, config_source_select}),
      .q      (sync_q)
   );
   assign {sclk_s, ssel_s, sdi_s, en_s, dir_s, strap_s} = sync_q;

   // Previous levels for edge detection
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclk_d_reg <= 1'b0;
         ssel_d_reg <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         ssel_d_reg <= ssel_s;
      end
   end
   assign sclk_rise = sclk_s & ~sclk_d_reg;
   assign ssel_rise = ssel_s & ~ssel_d_reg;
   assign ssel_fall = ~ssel_s & ssel_d_reg;

   // ==========================================================
   // Load sequencer and EEPROM master
   assign tick      = (half_reg == HW'(EE_HALF_CYC - 1));
   assign ee_active = (ld_reg == LD_EE_GAP) || (ld_reg == LD_EE_CMD) || (ld_reg == LD_EE_DATA);
   assign ee_wdata  = {ee_sr_reg[14:0], sdi_s};
   assign ee_wr     = tick && sk_reg && (ld_reg == LD_EE_DATA)
                      && (ee_bit_reg == crol_pkg::EE_DATA_BITS - 5'h01);

   // Strap decides the source once reset is released
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ld_reg      <= LD_SETTLE;
         settle_reg  <= 3'h0;
         half_reg    <= '0;
         sk_reg      <= 1'b0;
         cs_reg      <= 1'b0;
         cmd_reg     <= 9'h000;
         ee_bit_reg  <= 5'h00;
         ee_word_reg <= 4'h0;
         ee_sr_reg   <= 16'h0000;
      end else begin
         case (ld_reg)
            LD_SETTLE: begin
               settle_reg <= settle_reg + 3'h1;
               if (settle_reg == crol_pkg::SETTLE_CYC) begin
                  ld_reg <= strap_s ? LD_EE_GAP : LD_OTP;
               end
            end
            LD_OTP: begin
               ld_reg <= LD_DONE;
            end
            LD_EE_GAP: begin
               half_reg <= tick ? '0 : half_reg + 1'b1;
               if (tick) begin
                  if (ee_word_reg == 4'(crol_pkg::NREG)) begin
                     ld_reg <= LD_DONE;
                  end else begin
                     cs_reg     <= 1'b1;
                     cmd_reg    <= {crol_pkg::EE_READ_OP, 2'h0, ee_word_reg};
                     ee_bit_reg <= 5'h00;
                     ld_reg     <= LD_EE_CMD;
                  end
               end
            end
            LD_EE_CMD, LD_EE_DATA: begin
               half_reg <= tick ? '0 : half_reg + 1'b1;
               if (tick) begin
                  sk_reg <= ~sk_reg;
                  // Falling serial clock edge: shift out, sample in
                  if (sk_reg) begin
                     ee_bit_reg <= ee_bit_reg + 5'h01;
                     if (ld_reg == LD_EE_CMD) begin
                        cmd_reg <= {cmd_reg[7:0], 1'b0};
                        if (ee_bit_reg == crol_pkg::EE_CMD_BITS - 5'h01) begin
                           ee_bit_reg <= 5'h00;
                           ld_reg     <= LD_EE_DATA;
                        end
                     end else begin
                        ee_sr_reg <= ee_wdata;
                        if (ee_wr) begin
                           cs_reg      <= 1'b0;
                           ee_word_reg <= ee_word_reg + 4'h1;
                           ld_reg      <= LD_EE_GAP;
                        end
                     end
                  end
               end
            end
            LD_DONE: begin
               ld_reg <= LD_DONE;
            end
            default: begin
               ld_reg <= LD_SETTLE;
            end
         endcase
      end
   end

   // Master drives clock and select only while loading
   assign serial_clk_out    = sk_reg;
   assign serial_clk_oe     = ee_active;
   assign serial_select_out = cs_reg;
   assign serial_select_oe  = ee_active;
   assign serial_dout       = ee_active ? cmd_reg[8] : rd_sr_reg[15];
   assign load_done         = (ld_reg == LD_DONE);

   ee_select_a: assert property (ld_reg == LD_EE_CMD |-> serial_select_out && serial_select_oe)
      else $error("EEPROM select not driven during command");

   // ==========================================================
   // Serial slave shifter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         spi_sr_reg  <= 24'h000000;
         spi_cnt_reg <= 5'h00;
         rd_sr_reg   <= 16'h0000;
      end else if (ssel_rise) begin
         spi_cnt_reg <= 5'h00;
         rd_sr_reg   <= 16'h0000;
      end else if (ssel_s && sclk_rise && spi_cnt_reg != 5'(crol_pkg::FRAME_BITS)) begin
         spi_sr_reg  <= {spi_sr_reg[22:0], sdi_s};
         spi_cnt_reg <= spi_cnt_reg + 5'h01;
         if (spi_cnt_reg == 5'(crol_pkg::HDR_BITS - 1)) begin
            rd_sr_reg <= rd_data;
         end else begin
            rd_sr_reg <= {rd_sr_reg[14:0], 1'b0};
         end
      end
   end

   // Read data for the address just completed
   assign rd_addr = {spi_sr_reg[5:0], sdi_s};
   always_comb begin
      rd_data = 16'h0000;
      if (rd_addr <= crol_pkg::ADDR_LAST) begin
         rd_data = regs_reg[rd_addr[3:0]];
      end else if (rd_addr == crol_pkg::ADDR_FAULT) begin
         rd_data = fault_reg;
      end
   end

   // Frame commits when select falls after 24 bits
   assign frm      = crol_pkg::crol_frame_t'(spi_sr_reg);
   assign wr_pulse = ssel_fall && !frm.rw && load_done
                     && (spi_cnt_reg == 5'(crol_pkg::FRAME_BITS));
   assign key_wr   = wr_pulse && (frm.addr == crol_pkg::ADDR_KEY);
   assign cmd_wr   = wr_pulse && (frm.addr == crol_pkg::ADDR_BURN);

   // ==========================================================
   // Register bank
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regs_reg <= {crol_pkg::NREG{crol_pkg::CFG_RST}};
      end else if (ld_reg == LD_OTP) begin
         regs_reg <= otp_reg;
      end else if (ee_wr) begin
         regs_reg[ee_word_reg] <= ee_wdata;
      end else if (wr_pulse && frm.addr <= crol_pkg::ADDR_LAST) begin
         regs_reg[frm.addr[3:0]] <= frm.data;
      end
   end

   spi_commit_a: assert property (wr_pulse && frm.addr == crol_pkg::ADDR_MAIN
      |=> cfg_image[0] == $past(frm.data))
      else $error("Serial write not stored");

   otp_load_a: assert property (ld_reg == LD_OTP |=> cfg_image == $past(otp_reg) && load_done)
      else $error("Fuse image not loaded");

   // Fault flags: hardware sets, software clears with zeros
   always_comb begin
      fault_next = fault_reg;
      if (wr_pulse && frm.addr == crol_pkg::ADDR_FAULT) begin
         fault_next = fault_reg & frm.data;
      end
      fault_next = (fault_next | 16'(fault_events)) & crol_pkg::FAULT_MASK;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fault_reg <= crol_pkg::FAULT_RST;
      end else begin
         fault_reg <= fault_next;
      end
   end

   fault_set_a: assert property (|fault_events
      |=> (fault_flags[5:0] & $past(fault_events)) == $past(fault_events))
      else $error("Fault event lost");

   fault_no_set_a: assert property (fault_events == 6'h00
      |=> (fault_flags & ~$past(fault_flags)) == 16'h0000)
      else $error("Fault flag set without event");

   // ==========================================================
   // Fuse unlock and burn sequence
   assign en_active = en_s ^ main_cfg.enable_polarity;
   assign burn_go   = (bn_reg == BN_FIRE) && key_wr && en_active
                      && (frm.data == crol_pkg::BURN_FIRE);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bn_reg   <= BN_KEY;
         key_reg  <= 2'h0;
         wait_reg <= '0;
      end else if (!en_active) begin
         bn_reg  <= BN_KEY;
         key_reg <= 2'h0;
      end else begin
         case (bn_reg)
            BN_KEY: begin
               if (key_wr && frm.data == crol_pkg::KEYS[key_reg]) begin
                  key_reg <= key_reg + 2'h1;
                  if (key_reg == 2'h3) begin
                     bn_reg <= BN_CMD;
                  end
               end else if (key_wr || cmd_wr) begin
                  key_reg <= 2'h0;
               end
            end
            BN_CMD: begin
               if (cmd_wr && frm.data == crol_pkg::BURN_CMD) begin
                  bn_reg   <= BN_WAIT;
                  wait_reg <= '0;
               end else if (key_wr || cmd_wr) begin
                  bn_reg  <= BN_KEY;
                  key_reg <= 2'h0;
               end
            end
            BN_WAIT: begin
               if (key_wr || cmd_wr) begin
                  bn_reg  <= BN_KEY;
                  key_reg <= 2'h0;
               end else if (wait_reg == WW'(BURN_WAIT_CYC - 1)) begin
                  bn_reg <= BN_FIRE;
               end else begin
                  wait_reg <= wait_reg + 1'b1;
               end
            end
            BN_FIRE: begin
               if (key_wr || cmd_wr) begin
                  bn_reg  <= BN_KEY;
                  key_reg <= 2'h0;
               end
            end
            default: begin
               bn_reg <= BN_KEY;
            end
         endcase
      end
   end
   assign burn_armed = (bn_reg == BN_FIRE);

   sequence s_cmd_ok;
      bn_reg == BN_CMD && cmd_wr && en_active && frm.data == crol_pkg::BURN_CMD;
   endsequence

   sequence s_waiting;
      bn_reg == BN_WAIT && !burn_go;
   endsequence

   burn_wait_a: assert property (s_cmd_ok |=> s_waiting)
      else $error("Burn command did not start the wait");

   burn_time_a: assert property (burn_go |-> wait_reg == WW'(BURN_WAIT_CYC - 1))
      else $error("Burn fired before the wait elapsed");

   key_abort_a: assert property (bn_reg == BN_KEY && key_wr && en_active
      && frm.data != crol_pkg::KEYS[key_reg] |=> key_reg == 2'h0 && bn_reg == BN_KEY)
      else $error("Wrong key did not abandon sequence");

   enable_abort_a: assert property (!en_active |=> bn_reg == BN_KEY && !burn_armed)
      else $error("Sequence survived loss of enable");

   // ==========================================================
   // Fuse array, written once
   always_ff @(posedge clk or negedge otp_blank_n) begin
      if (!otp_blank_n) begin
         otp_reg      <= '0;
         otp_prog_reg <= 1'b0;
      end else if (burn_go && !otp_prog_reg) begin
         otp_reg      <= regs_reg;
         otp_prog_reg <= 1'b1;
      end
   end
   assign otp_programmed = otp_prog_reg;

   otp_once_a: assert property (otp_programmed |=> $stable(otp_reg) && otp_programmed)
      else $error("Fuse array changed after programming");

   // ==========================================================
   // Decoded outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         motor_en_reg <= 1'b0;
         dir_reg      <= 1'b0;
         ag_hz_reg    <= 17'h00000;
      end else begin
         motor_en_reg <= en_active;
         dir_reg      <= dir_s ^ main_cfg.direction_polarity;
         ag_hz_reg    <= crol_pkg::AG_HZ[main_cfg.autogain_setpoint_select];
      end
   end

   // Field views of the register bank
   assign cfg_image            = regs_reg;
   assign main_cfg             = crol_pkg::crol_main_t'(regs_reg[crol_pkg::ADDR_MAIN[3:0]]);
   assign drive_cfg            = crol_pkg::crol_drive_t'(regs_reg[crol_pkg::ADDR_DRIVE[3:0]]);
   assign prot_cfg             = crol_pkg::crol_prot_t'(regs_reg[crol_pkg::ADDR_PROT[3:0]]);
   assign fault_flags          = fault_reg;
   assign motor_enable         = motor_en_reg;
   assign direction_out        = dir_reg;
   assign autogain_setpoint_hz = ag_hz_reg;

   motor_enable_a: assert property (##1 motor_enable == $past(en_s ^ regs_reg[0][11]))
      else $error("Enable polarity wrong");

   direction_a: assert property (##1 direction_out == $past(dir_s ^ regs_reg[0][10]))
      else $error("Direction polarity wrong");

   autogain_a: assert property (regs_reg[0][15:12] == 4'hf ##1 $stable(regs_reg[0])
      |=> autogain_setpoint_hz == 17'h17ed0)
      else $error("Autogain decode wrong");

endmodule

// ---- src/crol_sync.sv ----
`timescale 1ns/1ps
// ==========================================================
// Two-stage synchroniser for pin inputs
module crol_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Asynchronous inputs and synchronised outputs
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

// ---- testbench/crol_host.sv ----
`timescale 1ns/1ps
// ==========
// Serial host model
module crol_host (
   // Pins
   input  wire logic clk,
   input  wire logic sdout,
   output logic      sclk,
   output logic      ssel,
   output logic      sdin
);
   // Idle wire levels
   initial begin
      sclk = 1'b0;
      ssel = 1'b0;
      sdin = 1'b0;
   end
   // One frame, MSB first, 4-clk half periods; read bits taken at falling edges
   task automatic frame(input logic [23:0] f, output logic [15:0] r);
      r = 16'h0000;
      ssel <= 1'b1;
      for (int i = 23; i >= 0; i--) begin
         sdin <= f[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         if (i >= 1 && i <= 16) r = {r[14:0], sdout};
      end
      ssel <= 1'b0;
      sdin <= ~f[0];
      repeat (8) @(posedge clk);
   endtask
endmodule

// ==========
// Serial EEPROM model, read command only
module crol_eeprom (
   // Pins
   input  wire logic sk,
   input  wire logic cs,
   input  wire logic di,
   output logic      dout
);
   logic [15:0] mem [12];
   logic [15:0] sr = 16'h0000;
   int          n  = 0;
   initial dout = 1'b0;
   // Nine command bits, a dummy zero, then the word MSB first
   always @(posedge sk or negedge cs) begin
      if (!cs) begin
         n    <= 0;
         dout <= 1'b0;
      end else if (n < 8) begin
         sr <= {sr[14:0], di};
         n  <= n + 1;
      end else if (n == 8) begin
         sr   <= (sr[7:3] == 5'b11000) ? mem[{sr[2:0], di}] : 16'h0000;
         dout <= 1'b0;
         n    <= 9;
      end else begin
         dout <= sr[15];
         sr   <= {sr[14:0], 1'b0};
      end
   end
endmodule

// ---- testbench/crol_tb_top.sv ----
`timescale 1ns/1ps
// ==========
// Loader bench
module crol_tb_top;
   logic                  clk = 1'b0;
   logic                  resetn = 1'b0;
   logic                  blank_n = 1'b0;
   logic                  en = 1'b1;
   logic                  dir = 1'b0;
   logic [5:0]            fev = 6'h00;
   logic                  strap = 1'b0;
   logic                  sclk, ssel, sdin, me, dout, prog, armed, done;
   logic                  sdo, eesk, eecs, eedo;
   logic [15:0]           ff, obs, rdat, img [12];
   logic [16:0]           ag;
   logic [15:0]           exp_q [$];
   int                    error_cnt = 0;
   int                    n_checks = 0;
   event                  shown;
   crol_pkg::crol_image_t cimg;
   crol_pkg::crol_main_t  mcfg;
   crol_pkg::crol_drive_t dcfg;
   crol_pkg::crol_prot_t  pcfg;
   always #4 clk = ~clk;
   crol_host host (.clk(clk), .sdout(sdo), .sclk(sclk), .ssel(ssel), .sdin(sdin));
   crol_eeprom ee (.sk(eesk), .cs(eecs), .di(sdo), .dout(eedo));
   crol_loader #(.BURN_WAIT_CYC(20), .EE_HALF_CYC(4)) dut (
      .clk(clk), .resetn(resetn), .otp_blank_n(blank_n), .config_source_select(strap),
      .enable_pin(en), .direction_input(dir), .serial_clk_in(sclk), .serial_clk_out(eesk),
      .serial_clk_oe(), .serial_select_in(ssel), .serial_select_out(eecs), .serial_select_oe(),
      .serial_din(strap ? eedo : sdin), .serial_dout(sdo), .fault_events(fev), .cfg_image(cimg),
      .main_cfg(mcfg), .drive_cfg(dcfg), .prot_cfg(pcfg), .fault_flags(ff),
      .autogain_setpoint_hz(ag), .motor_enable(me), .direction_out(dout),
      .load_done(done), .otp_programmed(prog), .burn_armed(armed));
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Oldest note against each shown result
   always @(shown) check(obs, exp_q.pop_front());
   task automatic expect_eq(input logic [15:0] e, input logic [15:0] g);
      exp_q.push_back(e);
      obs = g;
      -> shown;
      @(posedge clk);
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] unused_rd;
      host.frame({1'b0, a, d}, unused_rd);
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      host.frame({1'b1, a, 16'h0000}, d);
   endtask
   task automatic restart();
      resetn <= 1'b0;
      repeat (8) @(posedge clk);
      resetn  <= 1'b1;
      blank_n <= 1'b1;
      for (int i = 0; i < 4000 && done !== 1'b1; i++) @(posedge clk);
      expect_eq(16'h0001, {15'h0, done});
      repeat (2) @(posedge clk);
   endtask
   // Unlock, arm, fire
   task automatic burn(input logic [15:0] k3);
      for (int i = 0; i < 3; i++) wr(7'h2d, crol_pkg::KEYS[i]);
      wr(7'h2d, k3);
      wr(7'h39, crol_pkg::BURN_CMD);
      for (int i = 0; i < 60 && armed !== 1'b1; i++) @(posedge clk);
      wr(7'h2d, crol_pkg::BURN_FIRE);
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200us;
      error_cnt++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      void'($urandom(10));
      restart();
      for (int i = 0; i < 12; i++) expect_eq(16'h0000, cimg[i]);
      expect_eq(16'h0018, ff);
      $display("blank load test done");
      for (int i = 0; i < 12; i++) begin
         img[i] = 16'($urandom);
         if (i == 0) img[i][15:11] = 5'h1e;
         wr(7'(i), img[i]);
         expect_eq(img[i], cimg[i]);
      end
      dir <= 1'b1;
      repeat (6) @(posedge clk);
      expect_eq({15'h0, ~img[0][10]}, {15'h0, dout});
      expect_eq(16'h0001, {15'h0, me});
      expect_eq(img[0], mcfg);
      expect_eq(16'hbf68, ag[16:1]);
      expect_eq({15'h0, img[4][10]}, {15'h0, dcfg.auto_advance_en});
      expect_eq({8'h0, img[10][7:0]}, {8'h0, pcfg.loop_gain});
      rd(7'h05, rdat);
      expect_eq(img[5], rdat);
      expect_eq(img[5], cimg[5]);
      rd(7'h20, rdat);
      expect_eq(16'h0000, rdat);
      wr(7'h00, img[0] | 16'h0800);
      expect_eq(16'h0000, {15'h0, me});
      wr(7'h00, img[0]);
      $display("overwrite test done");
      burn(16'h1234);
      expect_eq(16'h0000, {15'h0, armed | prog});
      burn(crol_pkg::KEYS[3]);
      repeat (6) @(posedge clk);
      expect_eq(16'h0001, {15'h0, prog});
      $display("burn test done");
      fev <= 6'h3f;
      @(posedge clk);
      fev <= 6'h00;
      wr(7'h2a, 16'hfff5);
      expect_eq(16'h0035, ff);
      wr(7'h2a, 16'hffff);
      expect_eq(16'h0035, ff);
      rd(7'h2a, rdat);
      expect_eq(16'h0035, rdat);
      $display("fault test done");
      wr(7'h00, 16'h0000);
      burn(crol_pkg::KEYS[3]);
      restart();
      for (int i = 0; i < 12; i++) expect_eq(img[i], cimg[i]);
      wr(7'h0b, 16'h00a5);
      expect_eq(16'h00a5, cimg[11]);
      $display("reload test done");
      for (int i = 0; i < 12; i++) ee.mem[i] = 16'($urandom);
      strap <= 1'b1;
      restart();
      for (int i = 0; i < 12; i++) expect_eq(ee.mem[i], cimg[i]);
      $display("eeprom load test done");
      report_and_stop();
   end
endmodule
